// ---- gpio_pkg.sv ----
package gpio_pkg;
    // Register byte offsets (one port: input, direction, output; plus control and edge record)
    localparam logic [11:0] PIN_OFF = 12'h000;
    localparam logic [11:0] DIR_OFF = 12'h004;
    localparam logic [11:0] OUT_OFF = 12'h008;
    localparam logic [11:0] CTRL_OFF = 12'h00C;
    localparam logic [11:0] EDGE_OFF = 12'h010;
    // Field positions in the control register
    localparam int PUD_POS = 0;
    localparam int SLEEP_POS = 1;
    // Reset values
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] OUT_RST = 8'h00;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [7:0] SYNC_RST = 8'h00;
    // Port width
    localparam int PINS = 8;
    // Bus answer
    localparam logic [31:0] RD_ZERO = 32'h00000000;
    // Single-cycle access timing
    localparam int ACCESS_WAIT = 0;
endpackage

// ---- gpio_sync_if.sv ----
`timescale 1ns/100ps
interface gpio_sync_if;
    logic [7:0] pin_level;
    logic [7:0] clamp_n;
    logic [7:0] sync_q;
    modport core (output pin_level, output clamp_n, input sync_q);
    modport sync (input pin_level, input clamp_n, output sync_q);
endinterface

// ---- gpio_sync.sv ----
`timescale 1ns/100ps
module gpio_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin path
    gpio_sync_if.sync sif
);
    logic [7:0] latch_q;
    logic [7:0] gated;

    // Clamp to ground ahead of the input stage
    assign gated = sif.pin_level & sif.clamp_n;

    // Transparent while clock high, holds while low; non-blocking so the
    // register below still takes the level held through the low phase
    always_latch begin
        if (!presetn) begin
            latch_q <= gpio_pkg::SYNC_RST;
        end else if (pclk) begin
            latch_q <= gated;
        end
    end

    // Latch output captured on rising edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sif.sync_q <= gpio_pkg::SYNC_RST;
        end else begin
            sif.sync_q <= latch_q;
        end
    end
endmodule

// ---- gpio_port.sv ----
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/100ps
// What this block does
// - Each pin has direction, output/pull-up and synchronized input bits.
// - Direction one makes the pin output, zero makes it input.
// - Pull-up on only for direction 0, output 1, global disable 0.
// - Clearing output bit or choosing output direction turns pull-up off.
// - Output pin drives the output bit; global disable does not matter.
// - Reset tri-states every pin at once, without a clock.
// - Global pull-up disable kills all pull-ups; such pin floats.
// - Input bit shows the pin level in any direction.
// - Pin passes a clock-high transparent latch, then a rising-edge register.
// - External change reaches input bit within half to one and a half periods.
// - A written pin value shows in input bit one period later.
// - Deep sleep clamps each digital input to ground.
// - Pins with enabled external interrupt escape the sleep clamp.
// - Releasing the clamp makes a high disabled interrupt pin flag an edge.
// - Software pull-ups stay inactive while reset is asserted.
// - Input location read-only; output and direction locations read/write.
module gpio_port (
    // APB
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe_n,
    output logic [7:0] pad_pullup,
    // Sleep controller and external interrupt enables
    input wire logic sleep_clamp,
    input wire logic [7:0] ext_int_en,
    // Synchronized input to interrupt logic
    output logic [7:0] pin_input_sync_bit
);
    logic [7:0] port_direction_register;
    logic [7:0] port_output_register;
    logic [1:0] special_function_io_register;
    logic [7:0] edge_seen_reg;
    logic [7:0] prev_sync_reg;
    logic global_pullup_disable;
    logic write_output_strobe;
    logic write_direction_strobe;
    logic write_ctrl_strobe;
    logic write_edge_strobe;
    logic read_pin_strobe;
    logic read_output_strobe;
    logic read_direction_strobe;
    logic access;
    logic [7:0] clamp_n;
    logic [7:0] sync_q;
    logic [7:0] pullup_next;
    gpio_sync_if sif ();

    // Decode of one access cycle
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // Zero-extend one port byte onto the read bus
    function automatic logic [31:0] rd_word(input logic [7:0] v);
        rd_word = {24'h000000, v};
    endfunction

    assign access = psel && penable;
    assign pready = 1'b1;
    assign write_output_strobe = access && pwrite && hit(paddr, gpio_pkg::OUT_OFF);
    assign write_direction_strobe = access && pwrite && hit(paddr, gpio_pkg::DIR_OFF);
    assign write_ctrl_strobe = access && pwrite && hit(paddr, gpio_pkg::CTRL_OFF);
    assign write_edge_strobe = access && pwrite && hit(paddr, gpio_pkg::EDGE_OFF);
    assign read_pin_strobe = hit(paddr, gpio_pkg::PIN_OFF);
    assign read_output_strobe = hit(paddr, gpio_pkg::OUT_OFF);
    assign read_direction_strobe = hit(paddr, gpio_pkg::DIR_OFF);
    assign global_pullup_disable = special_function_io_register[gpio_pkg::PUD_POS];

    // Unmapped addresses and writes to the input location give an error
    assign pslverr = access && !(hit(paddr, gpio_pkg::PIN_OFF) && !pwrite) &&
        !hit(paddr, gpio_pkg::OUT_OFF) && !hit(paddr, gpio_pkg::DIR_OFF) &&
        !hit(paddr, gpio_pkg::CTRL_OFF) && !hit(paddr, gpio_pkg::EDGE_OFF);

    // Direction register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_direction_register <= gpio_pkg::DIR_RST;
        end else if (write_direction_strobe) begin
            port_direction_register <= pwdata[7:0];
        end
    end

    // Output / pull-up register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_output_register <= gpio_pkg::OUT_RST;
        end else if (write_output_strobe) begin
            port_output_register <= pwdata[7:0];
        end
    end

    // Control register: pull-up disable and software sleep clamp
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            special_function_io_register <= gpio_pkg::CTRL_RST;
        end else if (write_ctrl_strobe) begin
            special_function_io_register <= pwdata[1:0];
        end
    end

    // Pad drive: output enable low while driving
    always_comb begin
        pad_out = port_output_register;
        pad_oe_n = presetn ? ~port_direction_register : 8'hFF;
        pullup_next = ~port_direction_register & port_output_register &
            {8{~global_pullup_disable}};
        pad_pullup = presetn ? pullup_next : 8'h00;
    end

    // Sleep clamp unless external interrupt is enabled on the pin
    assign clamp_n = (sleep_clamp || special_function_io_register[gpio_pkg::SLEEP_POS]) ?
        ext_int_en : 8'hFF;

    // Pin level, driven value included, goes to the synchronizer
    assign sif.pin_level = pad_in;
    assign sif.clamp_n = clamp_n;
    assign sync_q = sif.sync_q;
    assign pin_input_sync_bit = sync_q;

    gpio_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .sif(sif)
    );

    // Sticky record of input changes, shows clamp release edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_sync_reg <= gpio_pkg::SYNC_RST;
            edge_seen_reg <= gpio_pkg::SYNC_RST;
        end else begin
            prev_sync_reg <= sync_q;
            edge_seen_reg <= (edge_seen_reg & ~(write_edge_strobe ? pwdata[7:0] : 8'h00)) |
                (sync_q ^ prev_sync_reg);
        end
    end

    // Read data, registered in the setup phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= gpio_pkg::RD_ZERO;
        end else if (psel && !penable && !pwrite) begin
            if (read_pin_strobe) begin
                prdata <= rd_word(sync_q);
            end else if (read_direction_strobe) begin
                prdata <= rd_word(port_direction_register);
            end else if (read_output_strobe) begin
                prdata <= rd_word(port_output_register);
            end else if (hit(paddr, gpio_pkg::CTRL_OFF)) begin
                prdata <= rd_word({6'h00, special_function_io_register});
            end else if (hit(paddr, gpio_pkg::EDGE_OFF)) begin
                prdata <= rd_word(edge_seen_reg);
            end else begin
                prdata <= gpio_pkg::RD_ZERO;
            end
        end
    end

    // Checks
    property p_pullup_rule;
        @(posedge pclk) disable iff (!presetn)
        pad_pullup == (~port_direction_register & port_output_register &
            {8{~global_pullup_disable}});
    endproperty
    a_pullup_rule: assert property (p_pullup_rule) else $error("pull-up wrong");

    property p_drive;
        @(posedge pclk) disable iff (!presetn)
        (pad_oe_n == ~port_direction_register) && (pad_out == port_output_register);
    endproperty
    a_drive: assert property (p_drive) else $error("drive wrong");

    property p_dir_write;
        @(posedge pclk) disable iff (!presetn)
        write_direction_strobe |=> port_direction_register == $past(pwdata[7:0]);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction not stored");

    property p_out_write;
        @(posedge pclk) disable iff (!presetn)
        write_output_strobe |=> port_output_register == $past(pwdata[7:0]);
    endproperty
    a_out_write: assert property (p_out_write) else $error("output not stored");

    sequence s_live;
        $past(presetn) && (clamp_n == 8'hFF);
    endsequence
    property p_sync_delay;
        @(posedge pclk) disable iff (!presetn)
        s_live |=> sync_q == $past(pad_in);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("sync delay wrong");

    property p_clamp;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) && sleep_clamp |=> (sync_q & ~$past(ext_int_en)) == 8'h00;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp leaks");

    property p_clamp_escape;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) && sleep_clamp |=>
            (sync_q & $past(ext_int_en)) == ($past(pad_in) & $past(ext_int_en));
    endproperty
    a_clamp_escape: assert property (p_clamp_escape)
        else $error("interrupt pin clamped in sleep");

    property p_pud;
        @(posedge pclk) disable iff (!presetn)
        global_pullup_disable |-> pad_pullup == 8'h00;
    endproperty
    a_pud: assert property (p_pud) else $error("pull-up despite disable");

    property p_pin_ro;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && hit(paddr, gpio_pkg::PIN_OFF)) |-> pslverr;
    endproperty
    a_pin_ro: assert property (p_pin_ro) else $error("input location writable");

    // Reset forces every pad to tri-state with no pull-up
    property p_reset_tristate;
        @(posedge pclk)
        !presetn |-> pad_oe_n == 8'hFF;
    endproperty
    a_reset_tristate: assert property (p_reset_tristate)
        else $error("pins driven during reset");

    property p_reset_pullup;
        @(posedge pclk)
        !presetn |-> pad_pullup == 8'h00;
    endproperty
    a_reset_pullup: assert property (p_reset_pullup)
        else $error("pull-up active during reset");

    property p_pullup_inputs_only;
        @(posedge pclk) disable iff (!presetn)
        (pad_pullup & port_direction_register) == 8'h00;
    endproperty
    a_pullup_inputs_only: assert property (p_pullup_inputs_only)
        else $error("pull-up on an output pin");

    property p_pullup_needs_one;
        @(posedge pclk) disable iff (!presetn)
        (pad_pullup & ~port_output_register) == 8'h00;
    endproperty
    a_pullup_needs_one: assert property (p_pullup_needs_one)
        else $error("pull-up with output bit zero");

    property p_pullup_on;
        @(posedge pclk) disable iff (!presetn)
        !global_pullup_disable |->
            (pad_pullup | port_direction_register | ~port_output_register) == 8'hFF;
    endproperty
    a_pullup_on: assert property (p_pullup_on)
        else $error("pull-up missing on input pin");

    property p_pud_keeps_drive;
        @(posedge pclk) disable iff (!presetn)
        $rose(global_pullup_disable) |-> $stable(pad_oe_n) && $stable(pad_out);
    endproperty
    a_pud_keeps_drive: assert property (p_pud_keeps_drive)
        else $error("pull-up disable changed drive");

    property p_ctrl_write;
        @(posedge pclk) disable iff (!presetn)
        write_ctrl_strobe |=> special_function_io_register == $past(pwdata[1:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control not stored");

    property p_edge_set;
        @(posedge pclk) disable iff (!presetn)
        (sync_q != prev_sync_reg) |=>
            (edge_seen_reg & $past(sync_q ^ prev_sync_reg)) == $past(sync_q ^ prev_sync_reg);
    endproperty
    a_edge_set: assert property (p_edge_set)
        else $error("input change not flagged");

    property p_edge_clear;
        @(posedge pclk) disable iff (!presetn)
        write_edge_strobe && (sync_q == prev_sync_reg) |=>
            (edge_seen_reg & $past(pwdata[7:0])) == 8'h00;
    endproperty
    a_edge_clear: assert property (p_edge_clear)
        else $error("change flag not cleared");

    sequence s_read_setup(sel);
        psel && !penable && !pwrite && sel;
    endsequence

    property p_read_pin;
        @(posedge pclk) disable iff (!presetn)
        s_read_setup(read_pin_strobe) |=> prdata == {24'h000000, $past(sync_q)};
    endproperty
    a_read_pin: assert property (p_read_pin)
        else $error("input read wrong");

    property p_read_dir;
        @(posedge pclk) disable iff (!presetn)
        s_read_setup(read_direction_strobe) |=>
            prdata == {24'h000000, $past(port_direction_register)};
    endproperty
    a_read_dir: assert property (p_read_dir)
        else $error("direction read wrong");

    property p_read_out;
        @(posedge pclk) disable iff (!presetn)
        s_read_setup(read_output_strobe) |=>
            prdata == {24'h000000, $past(port_output_register)};
    endproperty
    a_read_out: assert property (p_read_out)
        else $error("output read wrong");

    property p_pin_no_write;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && hit(paddr, gpio_pkg::PIN_OFF)) |=>
            $stable(port_direction_register) && $stable(port_output_register);
    endproperty
    a_pin_no_write: assert property (p_pin_no_write)
        else $error("input location write had effect");

    property p_mapped_ok;
        @(posedge pclk) disable iff (!presetn)
        access && (hit(paddr, gpio_pkg::DIR_OFF) || hit(paddr, gpio_pkg::OUT_OFF)) |->
            !pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok)
        else $error("error on a mapped location");

    property p_upper_zero;
        @(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("read data above the port byte");
endmodule

// ---- gpio_pad_model.sv ----
`timescale 1ns/100ps
module gpio_pad_model (
    // Clock
    input wire logic pclk,
    // Design side of the pads
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe_n,
    input wire logic [7:0] pad_pullup,
    // External drivers
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Resolved pad level
    output logic [7:0] pad_in
);
    logic [7:0] float_q = 8'hA5;

    // A floating pad wanders every cycle, never holding the last level
    always_ff @(posedge pclk) begin
        float_q <= ~float_q;
    end

    // Own drive first, then external driver, then pull-up, else floating
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pad_oe_n[i]) begin
                pad_in[i] = pad_out[i];
            end else if (ext_en[i]) begin
                pad_in[i] = ext_val[i];
            end else if (pad_pullup[i]) begin
                pad_in[i] = 1'b1;
            end else begin
                pad_in[i] = float_q[i];
            end
        end
    end
endmodule

// ---- tb.sv ----
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin bad_count++; \
    $display("[ERR] %s exp %h got %h", nm, exp, got); end end
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, sleep_clamp = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic [7:0] pad_in, pad_out, pad_oe_n, pad_pullup, sync_bits, ext_int_en = 8'h00;
    logic [7:0] ext_en = 8'h00, ext_val = 8'h00;
    logic err;
    int bad_count = 0, total_checks = 0;

    // Clock at 40 MHz
    always #12.5 pclk = ~pclk;

    gpio_port gpio_port_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup(pad_pullup), .sleep_clamp(sleep_clamp), .ext_int_en(ext_int_en),
        .pin_input_sync_bit(sync_bits));

    gpio_pad_model gpio_pad_model_i (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One APB transfer: setup, access until pready, then release
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            bad_count++;
            final_report();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state
        apb(0, gpio_pkg::DIR_OFF, 0);
        `CHK("dir", 32'h00000000, rd)
        apb(0, gpio_pkg::OUT_OFF, 0);
        `CHK("out", 32'h00000000, rd)
        `CHK("oe_n", 8'hFF, pad_oe_n)
        `CHK("pullup", 8'h00, pad_pullup)
        $display("test reset done");
        // Mixed port: low nibble outputs, 4-5 pulled up, 6-7 driven outside
        ext_en <= 8'hC0;
        ext_val <= 8'h80;
        apb(1, gpio_pkg::OUT_OFF, 32'h00000035);
        apb(1, gpio_pkg::DIR_OFF, 32'h0000000F);
        @(posedge pclk);
        #1 `CHK("sync", 8'hB5, sync_bits)
        `CHK("oe_n", 8'hF0, pad_oe_n)
        `CHK("drive", 8'h05, pad_out & 8'h0F)
        `CHK("pullup", 8'h30, pad_pullup)
        apb(0, gpio_pkg::PIN_OFF, 0);
        `CHK("pin", 32'h000000B5, rd)
        apb(0, gpio_pkg::DIR_OFF, 0);
        `CHK("dir", 32'h0000000F, rd)
        $display("test config done");
        // External edge right at a rising edge shows one period later
        @(posedge pclk);
        ext_val <= 8'h00;
        #1 `CHK("sync", 8'hB5, sync_bits)
        @(posedge pclk);
        #1 `CHK("sync", 8'h35, sync_bits)
        // Global pull-up disable
        apb(1, gpio_pkg::CTRL_OFF, 32'h00000001);
        #1 `CHK("pullup", 8'h00, pad_pullup)
        `CHK("drive", 8'h05, pad_out & 8'h0F)
        apb(1, gpio_pkg::CTRL_OFF, 32'h00000000);
        $display("test pull-up disable done");
        // Refused accesses
        apb(1, gpio_pkg::PIN_OFF, 32'h000000FF);
        `CHK("err", 1'b1, err)
        apb(0, 12'h014, 0);
        `CHK("err", 1'b1, err)
        `CHK("rd", 32'h00000000, rd)
        $display("test refuse done");
        // Sleep clamp with one interrupt pin left open, then wake
        sleep_clamp <= 1'b1;
        ext_int_en <= 8'h01;
        repeat (3) @(posedge pclk);
        #1 `CHK("sync", 8'h01, sync_bits)
        apb(1, gpio_pkg::EDGE_OFF, 32'h000000FF);
        sleep_clamp <= 1'b0;
        ext_int_en <= 8'h00;
        repeat (3) @(posedge pclk);
        apb(0, gpio_pkg::EDGE_OFF, 0);
        `CHK("edge", 32'h00000034, rd)
        // Software sleep bit clamps every pin
        apb(1, gpio_pkg::CTRL_OFF, 32'h00000002);
        repeat (2) @(posedge pclk);
        #1 `CHK("sync", 8'h00, sync_bits)
        apb(1, gpio_pkg::CTRL_OFF, 32'h00000000);
        $display("test sleep done");
        // Reset in mid-run tri-states at once
        @(posedge pclk);
        presetn <= 1'b0;
        #1 `CHK("oe_n", 8'hFF, pad_oe_n)
        `CHK("pullup", 8'h00, pad_pullup)
        @(posedge pclk);
        presetn <= 1'b1;
        // Pull-up turned off by clearing output, then by output direction
        apb(1, gpio_pkg::OUT_OFF, 32'h00000030);
        #1 `CHK("pullup", 8'h30, pad_pullup)
        apb(1, gpio_pkg::OUT_OFF, 32'h00000010);
        #1 `CHK("pullup", 8'h10, pad_pullup)
        apb(1, gpio_pkg::DIR_OFF, 32'h00000010);
        #1 `CHK("pullup", 8'h00, pad_pullup)
        $display("test pull-up off done");
        final_report();
    end
endmodule
